// ### psr_flag_bank.sv
// sticky per-port flag bank with an interrupt-read-then-both-halves clear sequence
module psr_flag_bank #(
  parameter int N = 20
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] set_evt,
  input  wire logic         irq_rd,
  input  wire logic         low_rd,
  input  wire logic         high_rd,
  output logic      [N-1:0] flags,
  output logic              seq_armed
);

  typedef enum logic {SEQ_IDLE, SEQ_ARMED} psr_seq_t;

  psr_seq_t     state_r;
  logic         seen_low_r;
  logic         seen_high_r;
  logic         clr_now;
  logic [N-1:0] flags_r;

  // sequence completes on the read that supplies the last missing half
  assign clr_now = (state_r == SEQ_ARMED) && !irq_rd &&
                   (seen_low_r || low_rd) && (seen_high_r || high_rd);
  assign flags     = flags_r;
  assign seq_armed = (state_r == SEQ_ARMED);

  ////////////////////////////////////////////////////////////////////////////
  // a fresh interrupt register read always restarts the sequence
  // clear sequence arming
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= SEQ_IDLE;
    end else begin
      unique case (state_r)
        SEQ_IDLE: begin
          if (irq_rd) state_r <= SEQ_ARMED;
        end
        SEQ_ARMED: begin
          if (clr_now) state_r <= SEQ_IDLE;
        end
      endcase
    end
  end

  // halves may be read in either order, only after the arming read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seen_low_r  <= 1'b0;
      seen_high_r <= 1'b0;
    end else if (irq_rd || clr_now) begin
      seen_low_r  <= 1'b0;
      seen_high_r <= 1'b0;
    end else if (state_r == SEQ_ARMED) begin
      if (low_rd) seen_low_r <= 1'b1;
      if (high_rd) seen_high_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= (flags_r & ~{N{clr_now}}) | set_evt;
    end
  end

  a_set_wins_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    (set_evt != '0) |=> ((flags_r & $past(set_evt)) == $past(set_evt)))
    else $error("new detection lost during clear");

  a_hold_unarmed: assert property (
    @(posedge sys_clk) disable iff (rst)
    (state_r == SEQ_IDLE) |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("flag dropped without clear sequence");

  a_clear_needs_both: assert property (
    @(posedge sys_clk) disable iff (rst)
    clr_now |-> ((low_rd || seen_low_r) && (high_rd || seen_high_r)
                 && state_r == SEQ_ARMED))
    else $error("clear without both halves read");

  a_clear_takes_effect: assert property (
    @(posedge sys_clk) disable iff (rst)
    clr_now |=> (flags_r == $past(set_evt)))
    else $error("flags not cleared after sequence");

endmodule : psr_flag_bank

// ### psr_status_regs.sv
// port overcurrent and input-event status flags plus temperature result registers

package psr_pkg;
  localparam int          PORTS     = 20;
  localparam int          LOW_W     = 16;
  localparam int          HIGH_W    = 4;
  localparam int          TEMP_W    = 12;
  localparam int          RD_W      = 16;
  localparam int          ADDR_W    = 3;
  localparam int          MODE_W    = 2;
  // read indices of the result and status words
  localparam logic [2:0]  IDX_OC_LOW   = 3'h0;
  localparam logic [2:0]  IDX_OC_HIGH  = 3'h1;
  localparam logic [2:0]  IDX_TEMP_INT = 3'h2;
  localparam logic [2:0]  IDX_TEMP_EX1 = 3'h3;
  localparam logic [2:0]  IDX_TEMP_EX2 = 3'h4;
  localparam logic [2:0]  IDX_EV_LOW   = 3'h5;
  localparam logic [2:0]  IDX_EV_HIGH  = 3'h6;
  // trigger mode codes
  localparam logic [1:0]  MODE_NEVER   = 2'h0;
  localparam logic [1:0]  MODE_RISE    = 2'h1;
  localparam logic [1:0]  MODE_FALL    = 2'h2;
  localparam logic [1:0]  MODE_BOTH    = 2'h3;
  // reset values
  localparam logic [11:0] TEMP_RST     = 12'h000;
  localparam logic [15:0] RD_RST       = 16'h0000;
  // temperature scale, thousandths of a degree per lsb
  localparam int          TEMP_LSB_MC  = 125;
endpackage : psr_pkg

module psr_status_regs #(
  parameter int PORTS = psr_pkg::PORTS
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [PORTS-1:0]      oc_detect,
  input  wire logic [PORTS-1:0]      gpi_pin,
  input  wire logic [PORTS-1:0]      gpi_input_en,
  input  wire logic [2*PORTS-1:0]    input_event_trigger_mode,
  input  wire logic                  temp_int_valid,
  input  wire logic [11:0]           temp_int_sample,
  input  wire logic                  temp_ex1_valid,
  input  wire logic [11:0]           temp_ex1_sample,
  input  wire logic                  temp_ex2_valid,
  input  wire logic [11:0]           temp_ex2_sample,
  input  wire logic                  irq_reg_rd,
  input  wire logic                  rd_stb,
  input  wire logic [2:0]            rd_addr,
  output logic      [15:0]           rd_data,
  output logic                       rd_ack,
  output logic                       overcurrent_summary_irq,
  output logic                       input_event_summary_irq
);

  localparam int LW = psr_pkg::LOW_W;
  localparam int HW = psr_pkg::HIGH_W;

  logic [PORTS-1:0] oc_meta_r;
  logic [PORTS-1:0] oc_sync_r;
  logic [PORTS-1:0] gpi_meta_r;
  logic [PORTS-1:0] gpi_sync_r;
  logic [PORTS-1:0] gpi_prev_r;
  logic [PORTS-1:0] gpi_rise;
  logic [PORTS-1:0] gpi_fall;
  logic [PORTS-1:0] gpi_evt;
  logic [PORTS-1:0] driver_overcurrent_flags;
  logic [PORTS-1:0] input_event_flags;
  logic             oc_low_rd;
  logic             oc_high_rd;
  logic             ev_low_rd;
  logic             ev_high_rd;
  logic             oc_armed;
  logic             ev_armed;
  logic [11:0]      internal_temperature_result_r;
  logic [11:0]      external_temperature_one_result_r;
  logic [11:0]      external_temperature_two_result_r;
  logic [15:0]      rd_data_nxt;
  logic [15:0]      rd_data_r;
  logic             rd_ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // detector and pin levels are asynchronous: two flops before any use
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oc_meta_r <= '0;
      oc_sync_r <= '0;
    end else begin
      oc_meta_r <= oc_detect;
      oc_sync_r <= oc_meta_r;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpi_meta_r <= '0;
      gpi_sync_r <= '0;
    end else begin
      gpi_meta_r <= gpi_pin;
      gpi_sync_r <= gpi_meta_r;
    end
  end

  // previous synchronised level for edge finding
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpi_prev_r <= '0;
    end else begin
      gpi_prev_r <= gpi_sync_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge classification per port
  assign gpi_rise = gpi_sync_r & ~gpi_prev_r;
  assign gpi_fall = ~gpi_sync_r & gpi_prev_r;

  for (genvar i = 0; i < PORTS; i++) begin : g_evt
    logic [1:0] md;
    assign md = input_event_trigger_mode[2*i +: psr_pkg::MODE_W];
    assign gpi_evt[i] = gpi_input_en[i] &&
                        (((md == psr_pkg::MODE_RISE) && gpi_rise[i]) ||
                         ((md == psr_pkg::MODE_FALL) && gpi_fall[i]) ||
                         ((md == psr_pkg::MODE_BOTH) && (gpi_rise[i] || gpi_fall[i])));
  end

  ////////////////////////////////////////////////////////////////////////////
  // status-half read strobes feeding the clear sequences
  assign oc_low_rd  = rd_stb && (rd_addr == psr_pkg::IDX_OC_LOW);
  assign oc_high_rd = rd_stb && (rd_addr == psr_pkg::IDX_OC_HIGH);
  assign ev_low_rd  = rd_stb && (rd_addr == psr_pkg::IDX_EV_LOW);
  assign ev_high_rd = rd_stb && (rd_addr == psr_pkg::IDX_EV_HIGH);

  psr_flag_bank #(
    .N         (PORTS)
  ) u_oc_bank (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .set_evt   (oc_sync_r),
    .irq_rd    (irq_reg_rd),
    .low_rd    (oc_low_rd),
    .high_rd   (oc_high_rd),
    .flags     (driver_overcurrent_flags),
    .seq_armed (oc_armed)
  );

  psr_flag_bank #(
    .N         (PORTS)
  ) u_ev_bank (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .set_evt   (gpi_evt),
    .irq_rd    (irq_reg_rd),
    .low_rd    (ev_low_rd),
    .high_rd   (ev_high_rd),
    .flags     (input_event_flags),
    .seq_armed (ev_armed)
  );

  assign overcurrent_summary_irq = |driver_overcurrent_flags;
  assign input_event_summary_irq = |input_event_flags;

  ////////////////////////////////////////////////////////////////////////////
  // internal sample
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      internal_temperature_result_r <= psr_pkg::TEMP_RST;
    end else if (temp_int_valid) begin
      internal_temperature_result_r <= temp_int_sample;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      external_temperature_one_result_r <= psr_pkg::TEMP_RST;
    end else if (temp_ex1_valid) begin
      external_temperature_one_result_r <= temp_ex1_sample;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      external_temperature_two_result_r <= psr_pkg::TEMP_RST;
    end else if (temp_ex2_valid) begin
      external_temperature_two_result_r <= temp_ex2_sample;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unused upper bits and unmapped indices read as zero
  always_comb begin
    rd_data_nxt = psr_pkg::RD_RST;
    unique case (rd_addr)
      psr_pkg::IDX_OC_LOW:   rd_data_nxt = driver_overcurrent_flags[LW-1:0];
      psr_pkg::IDX_OC_HIGH:  rd_data_nxt = {12'h000, driver_overcurrent_flags[PORTS-1:LW]};
      // raw two's complement, no sign extension
      psr_pkg::IDX_TEMP_INT: rd_data_nxt = {4'h0, internal_temperature_result_r};
      psr_pkg::IDX_TEMP_EX1: rd_data_nxt = {4'h0, external_temperature_one_result_r};
      psr_pkg::IDX_TEMP_EX2: rd_data_nxt = {4'h0, external_temperature_two_result_r};
      psr_pkg::IDX_EV_LOW:   rd_data_nxt = input_event_flags[LW-1:0];
      psr_pkg::IDX_EV_HIGH:  rd_data_nxt = {12'h000, input_event_flags[PORTS-1:LW]};
      default:               rd_data_nxt = psr_pkg::RD_RST;
    endcase
  end

  // data captured at the read edge shows flags from before any clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= psr_pkg::RD_RST;
    end else if (rd_stb) begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // one-cycle acknowledge after each read strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_ack_r <= 1'b0;
    end else begin
      rd_ack_r <= rd_stb;
    end
  end

  assign rd_data = rd_data_r;
  assign rd_ack  = rd_ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_oc_sets_flag: assert property (
    @(posedge sys_clk) disable iff (rst)
    oc_detect[0] ##1 oc_detect[0] ##1 oc_detect[0] |=> driver_overcurrent_flags[0])
    else $error("overcurrent detection did not set flag");

  a_rise_sets_event: assert property (
    @(posedge sys_clk) disable iff (rst)
    (gpi_rise[1] && gpi_input_en[1] &&
     input_event_trigger_mode[3:2] == psr_pkg::MODE_RISE) |=> input_event_flags[1])
    else $error("rising edge did not set event flag");

  a_never_mode_quiet: assert property (
    @(posedge sys_clk) disable iff (rst)
    (input_event_trigger_mode[1:0] == psr_pkg::MODE_NEVER) |-> !gpi_evt[0])
    else $error("mode 00 produced an event");

  a_disabled_port_quiet: assert property (
    @(posedge sys_clk) disable iff (rst)
    !gpi_input_en[5] |-> !gpi_evt[5])
    else $error("event on a port not configured as input");

  a_temp_whole_load: assert property (
    @(posedge sys_clk) disable iff (rst)
    temp_int_valid |=> (internal_temperature_result_r == $past(temp_int_sample)))
    else $error("internal temperature not loaded whole");

  a_temp_holds: assert property (
    @(posedge sys_clk) disable iff (rst)
    !temp_ex1_valid |=> $stable(external_temperature_one_result_r))
    else $error("temperature result changed without sample");

  a_oc_summary: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(driver_overcurrent_flags[PORTS-1]) |-> overcurrent_summary_irq)
    else $error("overcurrent summary missed a flag");

  a_rd_high_data: assert property (
    @(posedge sys_clk) disable iff (rst)
    (rd_stb && rd_addr == psr_pkg::IDX_EV_HIGH) |=>
      (rd_ack && rd_data == {12'h000, $past(input_event_flags[PORTS-1:LW])}))
    else $error("event high half read wrong");

  a_temp_zero_top: assert property (
    @(posedge sys_clk) disable iff (rst)
    (rd_stb && rd_addr == psr_pkg::IDX_TEMP_EX2) |=>
      (rd_data == {4'h0, $past(external_temperature_two_result_r)}))
    else $error("temperature read not 12-bit field");

  a_ev_needs_irq_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!ev_armed && !irq_reg_rd) ##1 ev_high_rd |=>
      ((input_event_flags & $past(input_event_flags)) == $past(input_event_flags)))
    else $error("event flags cleared without interrupt read");

  a_fall_sets_event: assert property (
    @(posedge sys_clk) disable iff (rst)
    (gpi_fall[2] && gpi_input_en[2] &&
     input_event_trigger_mode[5:4] == psr_pkg::MODE_FALL) |=> input_event_flags[2])
    else $error("falling edge did not set event flag");

  a_both_sets_event: assert property (
    @(posedge sys_clk) disable iff (rst)
    ((gpi_rise[3] || gpi_fall[3]) && gpi_input_en[3] &&
     input_event_trigger_mode[7:6] == psr_pkg::MODE_BOTH) |=> input_event_flags[3])
    else $error("either-edge mode missed an edge");

  a_rd_oc_high: assert property (
    @(posedge sys_clk) disable iff (rst)
    (rd_stb && rd_addr == psr_pkg::IDX_OC_HIGH) |=>
      (rd_ack && rd_data == {12'h000, $past(driver_overcurrent_flags[PORTS-1:LW])}))
    else $error("overcurrent high half read wrong");

  a_rd_ev_low: assert property (
    @(posedge sys_clk) disable iff (rst)
    (rd_stb && rd_addr == psr_pkg::IDX_EV_LOW) |=>
      (rd_ack && rd_data == $past(input_event_flags[LW-1:0])))
    else $error("event low half read wrong");

  a_ext2_whole_load: assert property (
    @(posedge sys_clk) disable iff (rst)
    temp_ex2_valid |=> (external_temperature_two_result_r == $past(temp_ex2_sample)))
    else $error("second external temperature not loaded");

  a_ev_summary_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    (input_event_flags == '0) |-> !input_event_summary_irq)
    else $error("event summary set with no flag");

endmodule : psr_status_regs

// ### psr_host_model.sv
// host-side model that reads the status and result words and runs the clear sequence
module psr_host_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_ack,
  output logic             rd_stb,
  output logic      [2:0]  rd_addr,
  output logic             irq_reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle levels; address is meaningless outside a request
  initial begin
    rd_stb     = 1'b0;
    rd_addr    = 3'h7;
    irq_reg_rd = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one read: strobe for one edge, then take data in the cycle the ack stands
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    int n;
    n = 0;
    wait (rst === 1'b0); // no request while the block is held in reset
    @(posedge sys_clk);
    #1;
    rd_stb  = 1'b1;
    rd_addr = a;
    @(posedge sys_clk);
    #1;
    rd_stb  = 1'b0;
    rd_addr = ~a; // scramble so a stale index is never read as valid
    // bounded wait so a silent design cannot hang the host
    while (rd_ack !== 1'b1 && n < 4) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    d = (rd_ack === 1'b1) ? rd_data : 16'hXXXX;
  endtask : rd

  // interrupt register read, seen by the block as a one-cycle pulse
  task automatic irq_rd();
    @(posedge sys_clk);
    #1;
    irq_reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    irq_reg_rd = 1'b0;
  endtask : irq_rd

  task automatic clear_bank(input logic [2:0] lo_a, input logic [2:0] hi_a,
                            output logic [15:0] lo, output logic [15:0] hi);
    irq_rd();
    rd(lo_a, lo);
    rd(hi_a, hi);
  endtask : clear_bank
endmodule : psr_host_model

// ### tb.sv
// self-checking bench for the port status and temperature result registers
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk, rst, link_clk, link_run;
  logic [19:0] oc_detect, gpi_pin, gpi_input_en;
  logic [39:0] input_event_trigger_mode;
  logic        temp_int_valid, temp_ex1_valid, temp_ex2_valid;
  logic [11:0] temp_int_sample, temp_ex1_sample, temp_ex2_sample;
  logic        irq_reg_rd, rd_stb, rd_ack;
  logic [2:0]  rd_addr;
  logic [15:0] rd_data, lo, hi, d;
  logic        overcurrent_summary_irq, input_event_summary_irq;
  logic [19:0] e;
  logic [11:0] samp [3];
  int          mismatches, n_checks, cyc;

  psr_status_regs psr_status_regs_i (
    .sys_clk(sys_clk), .rst(rst), .oc_detect(oc_detect), .gpi_pin(gpi_pin),
    .gpi_input_en(gpi_input_en), .input_event_trigger_mode(input_event_trigger_mode),
    .temp_int_valid(temp_int_valid), .temp_int_sample(temp_int_sample),
    .temp_ex1_valid(temp_ex1_valid), .temp_ex1_sample(temp_ex1_sample),
    .temp_ex2_valid(temp_ex2_valid), .temp_ex2_sample(temp_ex2_sample),
    .irq_reg_rd(irq_reg_rd), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_ack(rd_ack), .overcurrent_summary_irq(overcurrent_summary_irq),
    .input_event_summary_irq(input_event_summary_irq));

  psr_host_model psr_host_model_i (
    .sys_clk(sys_clk), .rst(rst), .rd_data(rd_data), .rd_ack(rd_ack),
    .rd_stb(rd_stb), .rd_addr(rd_addr), .irq_reg_rd(irq_reg_rd));

  ////////////////////////////////////////////////////////////////////////////////
  // system clock, and a link clock that only runs while a frame is open
  always #50 sys_clk = ~sys_clk;
  initial begin
    #37;
    forever begin
      #400;
      if (link_run) link_clk = ~link_clk;
    end
  end
  assign gpi_pin = {20{link_clk}}; // every port pin follows the link clock

  // hang guard: the whole run needs well under this many cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      $display("ERROR %0t: run did not finish", $time);
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
    logic [15:0] v;
    psr_host_model_i.rd(a, v);
    chk(v, exp);
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cyc

  // ports flagged by one pin edge, worked out from mode and enable tables
  function automatic logic [19:0] ev_exp(input logic rising);
    logic [19:0] m;
    logic [1:0]  md;
    m = '0;
    for (int i = 0; i < 20; i++) begin
      md = 2'(i % 4);
      if (gpi_input_en[i] && (md == psr_pkg::MODE_BOTH ||
          md == (rising ? psr_pkg::MODE_RISE : psr_pkg::MODE_FALL))) m[i] = 1'b1;
    end
    return m;
  endfunction : ev_exp

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    link_clk = 1'b0;
    link_run = 1'b0;
    oc_detect = '0;
    gpi_input_en = 20'h7FFDF; // ports 5 and 19 left as non-inputs
    for (int i = 0; i < 20; i++) input_event_trigger_mode[2*i +: 2] = 2'(i % 4);
    {temp_int_valid, temp_ex1_valid, temp_ex2_valid} = 3'h0;
    {temp_int_sample, temp_ex1_sample, temp_ex2_sample} = '0;
    mismatches = 0;
    n_checks = 0;
    cyc = 0;
    samp = '{12'h800, 12'h7FF, 12'hFF8};
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    // reset values of every index, the unmapped one included
    for (int a = 0; a < 8; a++) rd_chk(3'(a), 16'h0000);
    $display("test reset_values done");

    // three sensors load together; samples turn to junk once valid drops
    @(posedge sys_clk);
    #1;
    {temp_int_valid, temp_ex1_valid, temp_ex2_valid} = 3'h7;
    {temp_int_sample, temp_ex1_sample, temp_ex2_sample} = {samp[0], samp[1], samp[2]};
    @(posedge sys_clk);
    #1;
    {temp_int_valid, temp_ex1_valid, temp_ex2_valid} = 3'h0;
    {temp_int_sample, temp_ex1_sample, temp_ex2_sample} = ~{samp[0], samp[1], samp[2]};
    for (int k = 0; k < 3; k++) rd_chk(3'(2 + k), {4'h0, samp[k]});
    $display("test temperatures done");

    // overcurrent on ports 0,3,15,16,19; port 3 stays high across the clear
    oc_detect = 20'h98009;
    wait_cyc(5);
    oc_detect = 20'h00008;
    chk({15'h0000, overcurrent_summary_irq}, 16'h0001);
    rd_chk(psr_pkg::IDX_OC_LOW, 16'h8009);
    rd_chk(psr_pkg::IDX_OC_HIGH, 16'h0009);
    rd_chk(psr_pkg::IDX_OC_LOW, 16'h8009);
    psr_host_model_i.irq_rd();
    rd_chk(psr_pkg::IDX_OC_LOW, 16'h8009);
    psr_host_model_i.irq_rd();
    rd_chk(psr_pkg::IDX_OC_HIGH, 16'h0009);
    rd_chk(psr_pkg::IDX_OC_LOW, 16'h8009);
    rd_chk(psr_pkg::IDX_OC_LOW, 16'h0008);
    rd_chk(psr_pkg::IDX_OC_HIGH, 16'h0000);
    oc_detect = '0;
    wait_cyc(4);
    psr_host_model_i.clear_bank(psr_pkg::IDX_OC_LOW, psr_pkg::IDX_OC_HIGH, lo, hi);
    chk(lo, 16'h0008);
    chk({15'h0000, overcurrent_summary_irq}, 16'h0000);
    // short trip on port 17 only, gone before the clear completes
    oc_detect = 20'h20000;
    wait_cyc(4);
    oc_detect = '0;
    chk({15'h0000, overcurrent_summary_irq}, 16'h0001);
    psr_host_model_i.clear_bank(psr_pkg::IDX_OC_LOW, psr_pkg::IDX_OC_HIGH, lo, hi);
    chk(lo, 16'h0000);
    chk(hi, 16'h0002);
    chk({15'h0000, overcurrent_summary_irq}, 16'h0000);
    $display("test overcurrent done");

    // one rising then one falling link edge, each framed and then cleared
    for (int r = 1; r >= 0; r--) begin
      link_run = 1'b1;
      @(link_clk);
      link_run = 1'b0;
      e = ev_exp(r[0]);
      wait_cyc(6);
      chk({15'h0000, input_event_summary_irq}, 16'h0001);
      psr_host_model_i.clear_bank(psr_pkg::IDX_EV_LOW, psr_pkg::IDX_EV_HIGH, lo, hi);
      chk(lo, e[15:0]);
      chk(hi, {12'h000, e[19:16]});
      rd_chk(psr_pkg::IDX_EV_LOW, 16'h0000);
      rd_chk(psr_pkg::IDX_EV_HIGH, 16'h0000);
      chk({15'h0000, input_event_summary_irq}, 16'h0000);
    end
    $display("test input_events done");
    close_out();
  end
endmodule : tb
